// ===== bolim_top.sv
/*
  Brownout gain limiter, levels 3 and 2: configuration registers on a
  classic Wishbone slave, the limiter state machine and its interrupt.
  Assumes supply samples arrive on clk in threshold code units.

  // Overview of operation
  // [R1] Level 3 release interval codes 0-7 pick 5 to 1000 ms, default 1.
  // [R2] Level 3 ceiling 0 to -31 dB in 1 dB codes, default 0Ch.
  // [R3] Level 3 threshold in 0.05 V codes against selected supply sample.
  // [R4] Level 3 hold 0 to 2000 ms; code 7 holds until hold clear.
  // [R5] Level 3 disable bit 4 of hold register, reset 0.
  // [R6] Read-only state code: idle, attacking, holding, releasing per level.
  // [R7] Status freeze high stops state code updates for stable readback.
  // [R8] Level 2 dwell codes pick 0 to 8000 us, default 0.
  // [R9] Level 2 attack step -0.0625 dB up to -6 dB, default 1.
  // [R10] Level 2 attack interval 2.5 to 500 us per step, default 0.
  // [R11] Level 2 release step 0.0625 dB up to 6 dB, default 3.
  // [R12] Level 2 release interval 5 to 1000 ms, default 1.
  // [R13] Level 2 ceiling 0 to -31 dB, default 12h.
  // [R14] Writing 1 to hold clear ends infinite hold; bit clears itself.
  // [R15] Global ceiling caps total attenuation; codes 2Fh and up disable it.
  // [R16] Dwell, attack to ceiling, hold, then release in steps.
*/
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module bolim_top
#(
	parameter bolim_pkg::bolim_tbl_t REL_CYC   = bolim_pkg::REL_CYC_DEF,
	parameter bolim_pkg::bolim_tbl_t HOLD_CYC  = bolim_pkg::HOLD_CYC_DEF,
	parameter bolim_pkg::bolim_tbl_t DWELL_CYC = bolim_pkg::DWELL_CYC_DEF,
	parameter bolim_pkg::bolim_tbl_t ATK_CYC   = bolim_pkg::ATK_CYC_DEF
)
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [7:0]  battery_sample,
	input  wire logic [7:0]  main_sample,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq,
	output logic      [19:0] gain_reduction
);

	typedef struct packed
	{
		logic                     ack;
		logic [31:0]              dat;
		logic [7:0]               l3rc;
		logic [7:0]               l3th;
		logic [7:0]               l3hs;
		logic [7:0]               l2da;
		logic [7:0]               l2ar;
		logic [7:0]               l2rc;
		logic [7:0]               ctrl;
		logic [6:0]               gceil;
		logic [7:0]               l2th;
		logic [7:0]               l2hd;
		logic [7:0]               l3da;
		logic [7:0]               l3ar;
		logic [2:0]               irq_st;
		logic [2:0]               irq_en;
		logic                     irq;
		bolim_pkg::bolim_state_e  st;
		logic                     lvl2;
		logic [19:0]              att;
		logic [3:0]               code;
		logic                     hclr;
	} bolim_top_s;

	localparam bolim_top_s RST = '{
		l3rc:   bolim_pkg::RST_L3RC,
		l3th:   bolim_pkg::RST_L3TH,
		l3hs:   bolim_pkg::RST_L3HS,
		l2da:   bolim_pkg::RST_L2DA,
		l2ar:   bolim_pkg::RST_L2AR,
		l2rc:   bolim_pkg::RST_L2RC,
		ctrl:   bolim_pkg::RST_CTRL,
		gceil:  bolim_pkg::RST_GCEIL,
		l2th:   bolim_pkg::RST_L2TH,
		l2hd:   bolim_pkg::RST_L2HD,
		l3da:   bolim_pkg::RST_L2DA,
		l3ar:   bolim_pkg::RST_L2AR,
		st:     bolim_pkg::ST_IDLE,
		code:   bolim_pkg::CODE_IDLE,
		default: '0
	};

	bolim_top_s  r;
	bolim_top_s  n;

	logic        req;
	logic        wr;
	logic [5:0]  idx;
	logic [7:0]  rdat;
	logic [2:0]  irq_clr;
	logic [2:0]  ev;
	logic        en;
	logic [7:0]  smp;
	logic        trig3;
	logic        trig2;
	logic        lsel;
	logic        trig_cur;
	logic [7:0]  cfg_da;
	logic [7:0]  cfg_ar;
	logic [7:0]  cfg_rc;
	logic [7:0]  cfg_hd;
	logic [19:0] ceil_lvl;
	logic [19:0] ceil_glb;
	logic [19:0] ceil_eff;
	logic [19:0] atk_step;
	logic [19:0] rel_step;
	logic [20:0] att_sum;
	logic        tmr_start;
	logic [31:0] tmr_load;
	logic        tmr_done;

	// ****************************************
	// Step decoders and interval timer
	// ****************************************
	bolim_step  u_atk_step (.code (cfg_da[bolim_pkg::STEP_LSB +: 4]), .step (atk_step));
	bolim_step  u_rel_step (.code (cfg_ar[bolim_pkg::STEP_LSB +: 4]), .step (rel_step));
	bolim_timer u_timer (.clk (clk), .nrst (nrst), .start (tmr_start), .load (tmr_load), .done (tmr_done));

	// ****************************************
	// Level selection and limits
	// ****************************************
	always_comb
	begin
		en = r.ctrl[bolim_pkg::CTRL_EN];
		smp = r.ctrl[bolim_pkg::CTRL_SRC] ? main_sample : battery_sample;
		trig3 = en & ~r.l3hs[bolim_pkg::DIS_BIT] & (smp < r.l3th); // see [R3] see [R5]
		trig2 = en & ~r.l2hd[bolim_pkg::DIS_BIT] & (smp < r.l2th);
		lsel = r.lvl2 | trig2;
		trig_cur = lsel ? trig2 : trig3;
		cfg_da = lsel ? r.l2da : r.l3da;
		cfg_ar = lsel ? r.l2ar : r.l3ar;
		cfg_rc = lsel ? r.l2rc : r.l3rc;
		cfg_hd = lsel ? r.l2hd : r.l3hs;
		ceil_lvl = {15'h0000, cfg_rc[4:0]} * bolim_pkg::DB_UNIT; // see [R2] see [R13]
		ceil_glb = {13'h0000, r.gceil} * bolim_pkg::DB_UNIT;
		if (r.gceil < bolim_pkg::GCEIL_OFF && ceil_glb < ceil_lvl)
			ceil_eff = ceil_glb; // see [R15]
		else
			ceil_eff = ceil_lvl;
		att_sum = {1'b0, r.att} + {1'b0, atk_step}; // see [R9]
	end

	// ****************************************
	// Bus, limiter state machine, interrupt
	// ****************************************
	always_comb
	begin
		n = r;
		req = wb_cyc_i & wb_stb_i;
		idx = wb_adr_i[bolim_pkg::IDX_LSB +: bolim_pkg::IDX_W];
		n.ack = req & ~r.ack;
		wr = req & wb_we_i & r.ack & wb_sel_i[0];
		irq_clr = 3'h0;
		ev = 3'h0;
		tmr_start = 1'b0;
		tmr_load = 32'h00000000;
		n.hclr = 1'b0;

		case (idx)
			bolim_pkg::IX_L3RC:  rdat = r.l3rc;
			bolim_pkg::IX_L3TH:  rdat = r.l3th;
			bolim_pkg::IX_L3HS:  rdat = {r.l3hs[7:4], r.code}; // see [R6]
			bolim_pkg::IX_L2DA:  rdat = r.l2da;
			bolim_pkg::IX_L2AR:  rdat = r.l2ar;
			bolim_pkg::IX_L2RC:  rdat = r.l2rc;
			bolim_pkg::IX_CTRL:  rdat = r.ctrl;
			bolim_pkg::IX_GCEIL: rdat = {1'b0, r.gceil};
			bolim_pkg::IX_L2TH:  rdat = r.l2th;
			bolim_pkg::IX_L2HD:  rdat = r.l2hd;
			bolim_pkg::IX_L3DA:  rdat = r.l3da;
			bolim_pkg::IX_L3AR:  rdat = r.l3ar;
			bolim_pkg::IX_IRQST: rdat = {5'h00, r.irq_st};
			bolim_pkg::IX_IRQEN: rdat = {5'h00, r.irq_en};
			default:             rdat = 8'h00;
		endcase
		if (req & ~r.ack)
			n.dat = {24'h000000, rdat};

		if (wr)
		begin
			case (idx)
				bolim_pkg::IX_L3RC:  n.l3rc = wb_dat_i[7:0];
				bolim_pkg::IX_L3TH:  n.l3th = wb_dat_i[7:0];
				bolim_pkg::IX_L3HS:  n.l3hs = wb_dat_i[7:0] & bolim_pkg::MASK_HOLD;
				bolim_pkg::IX_L2DA:  n.l2da = wb_dat_i[7:0] & bolim_pkg::MASK_STEP;
				bolim_pkg::IX_L2AR:  n.l2ar = wb_dat_i[7:0] & bolim_pkg::MASK_STEP;
				bolim_pkg::IX_L2RC:  n.l2rc = wb_dat_i[7:0];
				bolim_pkg::IX_CTRL:
				begin
					n.ctrl = wb_dat_i[7:0] & bolim_pkg::MASK_CTRL;
					n.hclr = wb_dat_i[bolim_pkg::CTRL_HCLR]; // see [R14]
				end
				bolim_pkg::IX_GCEIL: n.gceil = wb_dat_i[6:0];
				bolim_pkg::IX_L2TH:  n.l2th = wb_dat_i[7:0];
				bolim_pkg::IX_L2HD:  n.l2hd = wb_dat_i[7:0] & bolim_pkg::MASK_HOLD;
				bolim_pkg::IX_L3DA:  n.l3da = wb_dat_i[7:0] & bolim_pkg::MASK_STEP;
				bolim_pkg::IX_L3AR:  n.l3ar = wb_dat_i[7:0] & bolim_pkg::MASK_STEP;
				bolim_pkg::IX_IRQCL: irq_clr = wb_dat_i[2:0];
				bolim_pkg::IX_IRQEN: n.irq_en = wb_dat_i[2:0];
				default:             n.irq_en = r.irq_en;
			endcase
		end

		case (r.st) // see [R16]
			bolim_pkg::ST_IDLE:
			begin
				if (trig2 | trig3)
				begin
					n.lvl2 = trig2;
					n.st = bolim_pkg::ST_DWELL;
					tmr_start = 1'b1;
					tmr_load = DWELL_CYC[cfg_da[bolim_pkg::TOP3_LSB +: 3]]; // see [R8]
				end
			end
			bolim_pkg::ST_DWELL:
			begin
				n.lvl2 = lsel;
				if (!trig_cur)
				begin
					n.st = bolim_pkg::ST_IDLE;
					n.lvl2 = 1'b0;
				end
				else if (tmr_done)
				begin
					n.st = bolim_pkg::ST_ATTACK;
					ev[bolim_pkg::IRQ_ATTACK] = 1'b1;
					tmr_start = 1'b1;
					tmr_load = ATK_CYC[cfg_ar[bolim_pkg::TOP3_LSB +: 3]]; // see [R10]
				end
			end
			bolim_pkg::ST_ATTACK:
			begin
				n.lvl2 = lsel;
				if (r.att >= ceil_eff || (tmr_done && att_sum >= {1'b0, ceil_eff}))
				begin
					n.att = ceil_eff;
					n.st = bolim_pkg::ST_HOLD;
					ev[bolim_pkg::IRQ_HOLD] = 1'b1;
					tmr_start = 1'b1;
					tmr_load = HOLD_CYC[cfg_hd[bolim_pkg::TOP3_LSB +: 3]]; // see [R4]
				end
				else if (tmr_done)
				begin
					n.att = att_sum[19:0];
					tmr_start = 1'b1;
					tmr_load = ATK_CYC[cfg_ar[bolim_pkg::TOP3_LSB +: 3]]; // see [R10]
				end
			end
			bolim_pkg::ST_HOLD:
			begin
				if (trig2 && !r.lvl2)
				begin
					n.lvl2 = 1'b1;
					n.st = bolim_pkg::ST_ATTACK;
					ev[bolim_pkg::IRQ_ATTACK] = 1'b1;
					tmr_start = 1'b1;
					tmr_load = ATK_CYC[cfg_ar[bolim_pkg::TOP3_LSB +: 3]];
				end
				else if (trig_cur)
				begin
					tmr_start = 1'b1;
					tmr_load = HOLD_CYC[cfg_hd[bolim_pkg::TOP3_LSB +: 3]];
				end
				else if (cfg_hd[bolim_pkg::TOP3_LSB +: 3] == bolim_pkg::HOLD_INF ? r.hclr : tmr_done) // see [R4] see [R14]
				begin
					n.st = bolim_pkg::ST_RELEASE;
					tmr_start = 1'b1;
					tmr_load = REL_CYC[cfg_rc[bolim_pkg::TOP3_LSB +: 3]]; // see [R1] see [R12]
				end
			end
			bolim_pkg::ST_RELEASE:
			begin
				if (trig2 | trig3)
				begin
					n.lvl2 = lsel;
					n.st = bolim_pkg::ST_ATTACK;
					ev[bolim_pkg::IRQ_ATTACK] = 1'b1;
					tmr_start = 1'b1;
					tmr_load = ATK_CYC[cfg_ar[bolim_pkg::TOP3_LSB +: 3]];
				end
				else if (tmr_done)
				begin
					if (r.att <= rel_step) // see [R11]
					begin
						n.att = 20'h00000;
						n.lvl2 = 1'b0;
						n.st = bolim_pkg::ST_IDLE;
						ev[bolim_pkg::IRQ_IDLE] = 1'b1;
					end
					else
					begin
						n.att = r.att - rel_step;
						tmr_start = 1'b1;
						tmr_load = REL_CYC[cfg_rc[bolim_pkg::TOP3_LSB +: 3]]; // see [R1] see [R12]
					end
				end
			end
			default:
			begin
				n.st = bolim_pkg::ST_IDLE;
				n.lvl2 = 1'b0;
			end
		endcase

		if (!en)
		begin
			n.st = bolim_pkg::ST_IDLE;
			n.lvl2 = 1'b0;
			n.att = 20'h00000;
		end
		else if (r.gceil < bolim_pkg::GCEIL_OFF && n.att > ceil_glb)
			n.att = ceil_glb; // see [R15]

		// Reported code tracks the registered state
		if (!r.ctrl[bolim_pkg::CTRL_FREEZE]) // see [R7]
		begin
			case (r.st) // see [R6]
				bolim_pkg::ST_ATTACK:  n.code = bolim_pkg::CODE_ATK3 + {3'h0, r.lvl2};
				bolim_pkg::ST_HOLD:    n.code = bolim_pkg::CODE_HOLD3 + {3'h0, r.lvl2};
				bolim_pkg::ST_RELEASE: n.code = bolim_pkg::CODE_REL3 + {3'h0, r.lvl2};
				default:               n.code = bolim_pkg::CODE_IDLE;
			endcase
		end

		// New events win over a clear in the same cycle
		n.irq_st = (r.irq_st & ~irq_clr) | ev;
		n.irq = |(n.irq_st & n.irq_en);
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			r <= RST;
		else
			r <= n;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign wb_dat_o = r.dat;
	assign wb_ack_o = r.ack;
	assign irq = r.irq;
	assign gain_reduction = r.att;

endmodule

`default_nettype wire

// ===== bolim_pkg.sv
/*
  Constants, tables and types of the brownout gain limiter block.
  Assumes a 25 MHz core clock and 8-bit registers on a 32-bit bus.
*/
`default_nettype none

package bolim_pkg;

	// ****************************************
	// Clock and time tables
	// ****************************************
	localparam longint unsigned CLK_HZ = 64'd25000000;
	localparam longint unsigned PER_MS = 64'd1000;
	localparam longint unsigned PER_US = 64'd1000000;
	localparam longint unsigned PER_NS = 64'd1000000000;

	typedef logic [31:0] bolim_tbl_t [8];

	localparam bolim_tbl_t REL_MS   = '{5, 10, 25, 50, 100, 250, 500, 1000};
	localparam bolim_tbl_t HOLD_MS  = '{0, 10, 100, 250, 500, 1000, 2000, 0};
	localparam bolim_tbl_t DWELL_US = '{0, 100, 250, 500, 1000, 2000, 4000, 8000};
	localparam bolim_tbl_t ATK_NS   = '{2500, 5000, 10000, 25000, 50000, 100000, 250000, 500000};

	// Rounds up to whole cycles; zero stays zero
	function automatic bolim_tbl_t bolim_to_cyc(input bolim_tbl_t t, input longint unsigned per_s);
		bolim_tbl_t        c;
		longint unsigned   p;
		for (int i = 0; i < 8; i++)
		begin
			p = longint'(t[i]) * CLK_HZ;
			c[i] = (t[i] == 32'h0) ? 32'h0 : 32'((p + per_s - 64'd1) / per_s);
		end
		return c;
	endfunction

	localparam bolim_tbl_t REL_CYC_DEF   = bolim_to_cyc(REL_MS, PER_MS);
	localparam bolim_tbl_t HOLD_CYC_DEF  = bolim_to_cyc(HOLD_MS, PER_MS);
	localparam bolim_tbl_t DWELL_CYC_DEF = bolim_to_cyc(DWELL_US, PER_US);
	localparam bolim_tbl_t ATK_CYC_DEF   = bolim_to_cyc(ATK_NS, PER_NS);
	localparam logic [2:0] HOLD_INF      = 3'h7;

	// ****************************************
	// Attenuation in units of 0.0001 dB
	// ****************************************
	localparam int         ATT_W     = 20;
	localparam logic [19:0] DB_UNIT  = 20'h02710;
	localparam logic [19:0] STEP_MIN = 20'h00271;
	localparam logic [19:0] STEP_ONE = 20'h01388;
	localparam logic [19:0] STEP_INC = 20'h00F76;
	localparam logic [19:0] STEP_MAX = 20'h0EA60;
	localparam logic [3:0]  STEP_TOP = 4'hF;
	localparam logic [6:0]  GCEIL_OFF = 7'h2F;

	// ****************************************
	// Register map (index, byte address is index times four)
	// ****************************************
	localparam int         IDX_LSB  = 2;
	localparam int         IDX_W    = 6;
	localparam logic [5:0] IX_L3RC  = 6'h21;
	localparam logic [5:0] IX_L3TH  = 6'h22;
	localparam logic [5:0] IX_L3HS  = 6'h23;
	localparam logic [5:0] IX_L2DA  = 6'h24;
	localparam logic [5:0] IX_L2AR  = 6'h25;
	localparam logic [5:0] IX_L2RC  = 6'h26;
	localparam logic [5:0] IX_CTRL  = 6'h30;
	localparam logic [5:0] IX_GCEIL = 6'h31;
	localparam logic [5:0] IX_L2TH  = 6'h32;
	localparam logic [5:0] IX_L2HD  = 6'h33;
	localparam logic [5:0] IX_L3DA  = 6'h34;
	localparam logic [5:0] IX_L3AR  = 6'h35;
	localparam logic [5:0] IX_IRQST = 6'h38;
	localparam logic [5:0] IX_IRQCL = 6'h39;
	localparam logic [5:0] IX_IRQEN = 6'h3A;

	localparam logic [7:0] RST_L3RC  = 8'h2C;
	localparam logic [7:0] RST_L3TH  = 8'h4C;
	localparam logic [7:0] RST_L3HS  = 8'h20;
	localparam logic [7:0] RST_L2DA  = 8'h02;
	localparam logic [7:0] RST_L2AR  = 8'h06;
	localparam logic [7:0] RST_L2RC  = 8'h32;
	localparam logic [7:0] RST_CTRL  = 8'h00;
	localparam logic [6:0] RST_GCEIL = 7'h32;
	localparam logic [7:0] RST_L2TH  = 8'h46;
	localparam logic [7:0] RST_L2HD  = 8'h20;

	localparam logic [7:0] MASK_HOLD = 8'hF0;
	localparam logic [7:0] MASK_STEP = 8'hFE;
	localparam logic [7:0] MASK_CTRL = 8'h07;

	// Field positions
	localparam int TOP3_LSB    = 5;
	localparam int STEP_LSB    = 1;
	localparam int DIS_BIT     = 4;
	localparam int CTRL_EN     = 0;
	localparam int CTRL_SRC    = 1;
	localparam int CTRL_FREEZE = 2;
	localparam int CTRL_HCLR   = 3;

	// Interrupt status bits
	localparam int IRQ_W      = 3;
	localparam int IRQ_ATTACK = 0;
	localparam int IRQ_HOLD   = 1;
	localparam int IRQ_IDLE   = 2;

	// ****************************************
	// Limiter states and reported codes
	// ****************************************
	typedef enum logic [4:0]
	{
		ST_IDLE    = 5'h01,
		ST_DWELL   = 5'h02,
		ST_ATTACK  = 5'h04,
		ST_HOLD    = 5'h08,
		ST_RELEASE = 5'h10
	} bolim_state_e;

	localparam logic [3:0] CODE_IDLE  = 4'h0;
	localparam logic [3:0] CODE_ATK3  = 4'h1;
	localparam logic [3:0] CODE_HOLD3 = 4'h5;
	localparam logic [3:0] CODE_REL3  = 4'h9;

endpackage

`default_nettype wire

// ===== bolim_step.sv
/*
  Step size decoder: 4-bit step code to attenuation in 0.0001 dB.
  Assumes the caller selects the code of the active level.
*/
`timescale 1ns/10ps
`default_nettype none

module bolim_step
(
	input  wire logic [3:0]  code,
	output logic      [19:0] step
);

	// ****************************************
	// Lookup
	// ****************************************
	always_comb
	begin
		if (code == 4'h0)
			step = bolim_pkg::STEP_MIN;
		else if (code == bolim_pkg::STEP_TOP)
			step = bolim_pkg::STEP_MAX;
		else
			step = bolim_pkg::STEP_ONE + bolim_pkg::STEP_INC * {16'h0000, code - 4'h1};
	end

endmodule

`default_nettype wire

// ===== bolim_timer.sv
/*
  Interval timer: loads a cycle count on start, pulses done when it runs out.
  Assumes start is driven by logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module bolim_timer
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        start,
	input  wire logic [31:0] load,
	output logic             done
);

	typedef struct packed
	{
		logic [31:0] cnt;
		logic        run;
		logic        done;
	} bolim_tmr_s;

	bolim_tmr_s r;
	bolim_tmr_s n;

	// ****************************************
	// Count down
	// ****************************************
	always_comb
	begin
		n = r;
		n.done = 1'b0;
		if (start)
		begin
			n.cnt = load;
			n.run = 1'b1;
		end
		else if (r.run)
		begin
			if (r.cnt <= 32'h1)
			begin
				n.run = 1'b0;
				n.done = 1'b1;
			end
			else
				n.cnt = r.cnt - 32'h1;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			r <= '0;
		else
			r <= n;
	end

	assign done = r.done;

endmodule

`default_nettype wire

// ===== bolim_top_properties.sv
/*
  Port checker for the brownout gain limiter top, bound into bolim_top.
  Assumes one clock domain and the one-cycle Wishbone answer of the block.
*/
`timescale 1ns/10ps
`default_nettype none

module bolim_top_properties
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [7:0]  battery_sample,
	input wire logic [7:0]  main_sample,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        irq,
	input wire logic [19:0] gain_reduction
);
	// ****************************************
	// Bus and attenuation properties
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence req_new;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !$past(wb_cyc_i && wb_stb_i);
	endsequence

	sequence ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	req_ack_a: assert property (req_new |=> ack_pulse)
		else $error("ack did not answer a new request after one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");
	read_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	read_unmapped_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] > 6'h3A |-> wb_dat_o == 32'h00000000)
		else $error("unmapped read not zero");
	state_code_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] == bolim_pkg::IX_L3HS
		|-> wb_dat_o[3:0] <= 4'hC)
		else $error("state code outside defined range");
	gain_ceiling_a: assert property (gain_reduction <= 20'h4BAF0)
		else $error("attenuation beyond largest ceiling");
	gain_step_a: assert property ((gain_reduction >= $past(gain_reduction) ?
		gain_reduction - $past(gain_reduction) : $past(gain_reduction) - gain_reduction) <= bolim_pkg::STEP_MAX)
		else $error("attenuation moved more than one largest step");
	data_hold_a: assert property ($fell(wb_ack_o) |-> $stable(wb_dat_o))
		else $error("read data changed without a new access");
endmodule

bind bolim_top bolim_top_properties u_props
(
	.clk            (clk),
	.nrst           (nrst),
	.wb_cyc_i       (wb_cyc_i),
	.wb_stb_i       (wb_stb_i),
	.wb_we_i        (wb_we_i),
	.wb_sel_i       (wb_sel_i),
	.wb_adr_i       (wb_adr_i),
	.wb_dat_i       (wb_dat_i),
	.battery_sample (battery_sample),
	.main_sample    (main_sample),
	.wb_dat_o       (wb_dat_o),
	.wb_ack_o       (wb_ack_o),
	.irq            (irq),
	.gain_reduction (gain_reduction)
);

`default_nettype wire

// ===== bolim_top_test.sv
/*
  Self-checking bench for bolim_top: registers, limiter run, hold, interrupt.
  Assumes the checker is bound in and short cycle tables are set here.
*/
`timescale 1ns/10ps
`default_nettype none

module bolim_top_test;
	localparam bolim_pkg::bolim_tbl_t TBL_S = '{2, 3, 4, 5, 6, 7, 8, 9};
	localparam bolim_pkg::bolim_tbl_t TBL_H = '{0, 30, 4, 5, 6, 7, 8, 0};
	localparam bolim_pkg::bolim_tbl_t TBL_D = '{0, 3, 4, 5, 6, 7, 8, 9};
	logic        clk, nrst, cyc, stb, we;
	logic [3:0]  sel;
	logic [7:0]  adr, bat, mains;
	logic [31:0] dat, dat_o;
	logic        ack, irq;
	logic [19:0] gain;
	int          mismatches = 0;
	int          num_checks = 0;

	bolim_top #(.REL_CYC(TBL_S), .HOLD_CYC(TBL_H), .DWELL_CYC(TBL_D), .ATK_CYC(TBL_S)) uut
	(
		.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel),
		.wb_adr_i(adr), .wb_dat_i(dat), .battery_sample(bat), .main_sample(mains),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .irq(irq), .gain_reduction(gain)
	);

	// ****************************************
	// Bus and compare tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h000000, d};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		q = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 20)
			chk("bus answer", 32'h1, 32'h0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		logic [7:0] q;
		xfer(1'b0, a, 8'h00, q);
		chk(nm, {24'h000000, e}, {24'h000000, q});
	endtask

	task automatic wait_gain(input logic [19:0] e, input string nm);
		int n;
		n = 0;
		while (gain !== e && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		chk(nm, {12'h000, e}, {12'h000, gain});
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic reset_values;
		logic [7:0] a [7] = '{8'h84, 8'h88, 8'h8C, 8'h90, 8'h94, 8'h98, 8'hFC};
		logic [7:0] e [7] = '{8'h2C, 8'h4C, 8'h20, 8'h02, 8'h06, 8'h32, 8'h00};
		for (int i = 0; i < 7; i++)
			rd(a[i], e[i], "reset value");
	endtask

	task automatic field_access;
		logic [7:0] w [6] = '{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
		logic [7:0] e [6] = '{8'hFF, 8'h00, 8'hF0, 8'hFE, 8'hFE, 8'hFF};
		logic [7:0] r [6] = '{8'h22, 8'h4C, 8'h20, 8'h02, 8'h06, 8'h32};
		logic [7:0] ad;
		for (int i = 0; i < 6; i++)
		begin
			ad = 8'h84 + 8'(i * 4);
			wr(ad, w[i]);
			rd(ad, e[i], "field access");
			wr(ad, r[i]);
		end
		wr(8'hFC, 8'h55);
		rd(8'hFC, 8'h00, "unmapped place");
	endtask

	task automatic limiter_run;
		wr(8'hC0, 8'h01);
		bat <= 8'h48;
		wait_gain(20'h04E20, "attack to ceiling");
		rd(8'h8C, 8'h25, "hold state");
		wr(8'hC0, 8'h05);
		bat <= 8'hFF;
		wait_gain(20'h00000, "release to zero");
		rd(8'h8C, 8'h25, "frozen state");
		wr(8'hC0, 8'h01);
		rd(8'h8C, 8'h20, "idle state");
		rd(8'hE0, 8'h07, "event status");
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(8'hE8, 8'h07);
		repeat (2) @(posedge clk);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(8'hE4, 8'h07);
		rd(8'hE0, 8'h00, "status cleared");
		repeat (2) @(posedge clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
	endtask

	task automatic infinite_hold;
		wr(8'hC4, 8'h01);
		wr(8'h8C, 8'hE0);
		wr(8'hC0, 8'h03);
		mains <= 8'h48;
		wait_gain(20'h02710, "global ceiling");
		mains <= 8'hFF;
		repeat (60) @(posedge clk);
		chk("infinite hold", 32'h02710, {12'h000, gain});
		wr(8'hC0, 8'h0B);
		wait_gain(20'h00000, "hold cleared");
		rd(8'hC0, 8'h03, "clear bit returns");
	endtask

	task automatic level_disable;
		wr(8'h8C, 8'h30);
		mains <= 8'h48;
		repeat (50) @(posedge clk);
		chk("level disabled", 32'h0, {12'h000, gain});
		mains <= 8'h40;
		wait_gain(20'h02710, "level 2 attack");
		rd(8'h8C, 8'h36, "level 2 hold");
		mains <= 8'hFF;
		wait_gain(20'h00000, "level 2 release");
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ****************************************
	// Clock, sequence and watchdog
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial
	begin
		nrst = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		sel = 4'hF;
		adr = 8'h00;
		dat = 32'h00000000;
		bat = 8'hFF;
		mains = 8'hFF;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		reset_values();
		field_access();
		limiter_run();
		infinite_hold();
		level_disable();
		final_report();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		final_report();
	end
endmodule

`default_nettype wire
